// ---- rtl/ues_regs.svh ----
`ifndef UES_REGS_SVH
`define UES_REGS_SVH

// bus geometry
`define UES_ADDR_W 12
`define UES_DATA_W 32

// register byte offsets
`define UES_SEV_OFS 12'h10C
`define UES_CTL_OFS 12'h200

// severity field positions
`define UES_COMPLETION_TIMEOUT_SEV_BIT 14
`define UES_COMPLETER_ABORT_SEV_BIT 15
`define UES_UNEXP_BIT 16
`define UES_RXOVF_BIT 17
`define UES_BADFMT_BIT 18
`define UES_ECRC_BIT 19
`define UES_UNSUP_BIT 20
`define UES_ACS_BIT 21
`define UES_INTERR_BIT 22
`define UES_MCBLK_BIT 23
`define UES_FIELD_LO 14
`define UES_FIELD_HI 23
`define UES_FIELD_N 10
`define UES_PROG_LO 16
`define UES_PROG_HI 23
`define UES_SEV_LANE 2

// severity reset value and forced values
`define UES_SEV_RST 8'h46
`define UES_INTERR_FORCED 1'b1
`define UES_MCBLK_FORCED 1'b0

// control register fields
`define UES_CTL_IEEN_BIT 0
`define UES_CTL_MCOFF_BIT 1
`define UES_CTL_LANE 0
`define UES_CTL_RST 2'h0

// bus responses
`define UES_RESP_OKAY 2'h0
`define UES_RESP_SLVERR 2'h2

`endif

// ---- rtl/ues_pkg.sv ----
package ues_pkg;
   `include "ues_regs.svh"

   // write request handed from the bus slave to the register bank
   typedef struct packed {
      logic [`UES_ADDR_W-1:0] addr;
      logic [`UES_DATA_W-1:0] data;
      logic [3:0] strb;
   } ues_wreq_t;

   // write channel states
   typedef enum logic [1:0] {
      UES_WR_COLLECT = 2'b01,
      UES_WR_RESP = 2'b10
   } ues_wr_state_t;
endpackage : ues_pkg

// ---- rtl/ues_axil_slave.sv ----
`timescale 1ns/1ps
`include "ues_regs.svh"
module ues_axil_slave
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // write address and data
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [`UES_ADDR_W-1:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [`UES_DATA_W-1:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   // write response
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   // read address and data
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [`UES_ADDR_W-1:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [`UES_DATA_W-1:0] s_rdata,
   output logic [1:0] s_rresp,
   // register bank side
   output logic wr_en,
   output ues_pkg::ues_wreq_t wr_req,
   input wire logic wr_ok,
   output logic [`UES_ADDR_W-1:0] rd_addr,
   input wire logic [`UES_DATA_W-1:0] rd_data,
   input wire logic rd_ok
);
   import ues_pkg::*;

   ues_wr_state_t wst_ff;
   logic aw_held_ff;
   logic w_held_ff;
   ues_wreq_t req_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [`UES_DATA_W-1:0] rdata_ff;
   logic [1:0] rresp_ff;

   // address and data are taken in either order, one write at a time
   assign s_awready = ce && !aw_held_ff && (wst_ff == UES_WR_COLLECT);
   assign s_wready = ce && !w_held_ff && (wst_ff == UES_WR_COLLECT);
   assign wr_en = ce && aw_held_ff && w_held_ff && (wst_ff == UES_WR_COLLECT);
   assign wr_req = req_ff;
   assign s_bvalid = (wst_ff == UES_WR_RESP);
   assign s_bresp = bresp_ff;

   // write channel capture and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wst_ff <= UES_WR_COLLECT;
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         req_ff <= '0;
         bresp_ff <= `UES_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_awvalid && s_awready)
         begin
            aw_held_ff <= 1'b1;
            req_ff.addr <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_held_ff <= 1'b1;
            req_ff.data <= s_wdata;
            req_ff.strb <= s_wstrb;
         end
         unique case (wst_ff)
            UES_WR_COLLECT:
               if (wr_en)
               begin
                  wst_ff <= UES_WR_RESP;
                  bresp_ff <= wr_ok ? `UES_RESP_OKAY : `UES_RESP_SLVERR;
               end
            UES_WR_RESP:
               if (s_bready)
               begin
                  wst_ff <= UES_WR_COLLECT;
                  aw_held_ff <= 1'b0;
                  w_held_ff <= 1'b0;
               end
         endcase
      end
   end

   // read: data is looked up at the address handshake, answered next cycle
   assign s_arready = ce && !rvalid_ff;
   assign rd_addr = s_araddr;
   assign s_rvalid = rvalid_ff;
   assign s_rdata = rdata_ff;
   assign s_rresp = rresp_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= `UES_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_arvalid && s_arready)
         begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_data;
            rresp_ff <= rd_ok ? `UES_RESP_OKAY : `UES_RESP_SLVERR;
         end
         else if (s_rready)
            rvalid_ff <= 1'b0;
      end
   end
endmodule : ues_axil_slave

// ---- rtl/ues_sev_report.sv ----
`timescale 1ns/1ps
`include "ues_regs.svh"
module ues_sev_report
#(
   parameter int N = `UES_FIELD_N
)
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // detected errors and effective severities
   input wire logic [N-1:0] err_evt,
   input wire logic [N-1:0] sev_eff,
   // classified reports
   output logic report_fatal,
   output logic report_nonfatal
);
   import ues_pkg::*;

   // any detected error whose selector is one counts as fatal
   function automatic logic any_set(input logic [N-1:0] evt, input logic [N-1:0] sel);
      any_set = |(evt & sel);
   endfunction : any_set

   // one registered pulse per class; both may fire in one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         report_fatal <= 1'b0;
         report_nonfatal <= 1'b0;
      end
      else if (ce)
      begin
         report_fatal <= any_set(err_evt, sev_eff); // RULE3
         report_nonfatal <= any_set(err_evt, ~sev_eff); // RULE3
      end
   end
endmodule : ues_sev_report

// ---- rtl/ues_top.sv ----
// Behaviour
// RULE1: completion-timeout severity bit 14 is read-only and always reads zero.
// RULE2: completer-abort severity bit 15 is read-only and resets to zero.
// RULE3: selectors 16 to 23 report their error fatal when one, non-fatal when zero.
// RULE4: after reset bits 17, 18, 22 read one; bits 16, 19-21, 23 read zero.
// RULE5: internal-error reporting disabled: bit 22 reads one and ignores writes.
// RULE6: multicast reporting not turned off: bit 23 reads zero and ignores writes.
// RULE7: selectors survive non-fundamental reset; bits 31 to 24 read zero, ignore writes.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ues_regs.svh"
module ues_top
(
   // clock, fundamental reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // non-fundamental reset, active high, clears bus state only
   input wire logic hot_reset,
   // axi4-lite write address and data
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [`UES_ADDR_W-1:0] s_awaddr,
   input wire logic [2:0] s_awprot,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [`UES_DATA_W-1:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   // axi4-lite write response
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   // axi4-lite read
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [`UES_ADDR_W-1:0] s_araddr,
   input wire logic [2:0] s_arprot,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [`UES_DATA_W-1:0] s_rdata,
   output logic [1:0] s_rresp,
   // detected uncorrectable errors, one pulse bit per field 14 to 23
   input wire logic [`UES_FIELD_N-1:0] err_evt,
   // classified reports and effective severities
   output logic report_fatal,
   output logic report_nonfatal,
   output logic [`UES_FIELD_N-1:0] sev_out
);
   import ues_pkg::*;

   localparam int PN = `UES_PROG_HI - `UES_PROG_LO + 1;

   logic bus_rst_n;
   logic wr_en;
   ues_wreq_t wr_req;
   logic wr_ok;
   logic [`UES_ADDR_W-1:0] rd_addr;
   logic [`UES_DATA_W-1:0] rd_data;
   logic rd_ok;
   logic [PN-1:0] sev_ff;
   logic [PN-1:0] nxt_sev;
   logic [1:0] ctl_ff;
   logic [1:0] nxt_ctl;
   logic ie_en;
   logic mc_off;
   logic [`UES_FIELD_N-1:0] sev_eff;
   logic [`UES_DATA_W-1:0] sev_word;
   logic [`UES_DATA_W-1:0] ctl_word;

   // register decode, used for both read and write
   function automatic logic hit(input logic [`UES_ADDR_W-1:0] a, input logic [`UES_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // bus state follows both resets; the severity bank only the fundamental one
   assign bus_rst_n = aresetn && !hot_reset; // RULE7

   ues_axil_slave u_bus
   (
      .aclk(aclk),
      .aresetn(bus_rst_n),
      .ce(ce),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_awaddr(s_awaddr),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_bresp(s_bresp),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_araddr(s_araddr),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .wr_en(wr_en),
      .wr_req(wr_req),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // control bits that gate the two conditional selectors
   assign ie_en = ctl_ff[`UES_CTL_IEEN_BIT];
   assign mc_off = ctl_ff[`UES_CTL_MCOFF_BIT];

   // effective view: 14 and 15 hardwired, 22 and 23 forced while locked
   always_comb
   begin
      sev_eff = '0;
      sev_eff[`UES_COMPLETION_TIMEOUT_SEV_BIT-`UES_FIELD_LO] = 1'b0; // RULE1
      sev_eff[`UES_COMPLETER_ABORT_SEV_BIT-`UES_FIELD_LO] = 1'b0; // RULE2
      sev_eff[`UES_FIELD_HI-`UES_FIELD_LO:`UES_PROG_LO-`UES_FIELD_LO] = sev_ff;
      if (!ie_en)
         sev_eff[`UES_INTERR_BIT-`UES_FIELD_LO] = `UES_INTERR_FORCED; // RULE5
      if (!mc_off)
         sev_eff[`UES_MCBLK_BIT-`UES_FIELD_LO] = `UES_MCBLK_FORCED; // RULE6
   end

   assign sev_out = sev_eff;

   // read words: lower bits 0-13 belong elsewhere, 31-24 reserved
   always_comb
   begin
      sev_word = '0; // RULE7
      sev_word[`UES_FIELD_HI:`UES_FIELD_LO] = sev_eff;
      ctl_word = '0;
      ctl_word[`UES_CTL_IEEN_BIT] = ie_en;
      ctl_word[`UES_CTL_MCOFF_BIT] = mc_off;
   end

   // read mux, unmapped addresses answer slverr with zero data
   always_comb
   begin
      rd_data = '0;
      rd_ok = 1'b1;
      if (hit(rd_addr, `UES_SEV_OFS))
         rd_data = sev_word;
      else if (hit(rd_addr, `UES_CTL_OFS))
         rd_data = ctl_word;
      else
         rd_ok = 1'b0;
   end

   assign wr_ok = hit(wr_req.addr, `UES_SEV_OFS) || hit(wr_req.addr, `UES_CTL_OFS);

   // next selector value; locked selectors keep their stored bit
   always_comb
   begin
      nxt_sev = sev_ff;
      if (wr_en && hit(wr_req.addr, `UES_SEV_OFS) && wr_req.strb[`UES_SEV_LANE])
      begin
         nxt_sev = wr_req.data[`UES_PROG_HI:`UES_PROG_LO]; // RULE3
         if (!ie_en)
            nxt_sev[`UES_INTERR_BIT-`UES_PROG_LO] = sev_ff[`UES_INTERR_BIT-`UES_PROG_LO]; // RULE5
         if (!mc_off)
            nxt_sev[`UES_MCBLK_BIT-`UES_PROG_LO] = sev_ff[`UES_MCBLK_BIT-`UES_PROG_LO]; // RULE6
      end
   end

   // sticky selectors: only the fundamental reset reloads their reset value
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sev_ff <= `UES_SEV_RST; // RULE4
      else if (ce)
         sev_ff <= nxt_sev; // RULE7
   end

   // control register, also sticky so a hot reset cannot unlock a selector
   always_comb
   begin
      nxt_ctl = ctl_ff;
      if (wr_en && hit(wr_req.addr, `UES_CTL_OFS) && wr_req.strb[`UES_CTL_LANE])
      begin
         nxt_ctl[`UES_CTL_IEEN_BIT] = wr_req.data[`UES_CTL_IEEN_BIT];
         nxt_ctl[`UES_CTL_MCOFF_BIT] = wr_req.data[`UES_CTL_MCOFF_BIT];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctl_ff <= `UES_CTL_RST;
      else if (ce)
         ctl_ff <= nxt_ctl;
   end

   // error classification from the effective selectors
   ues_sev_report #(.N(`UES_FIELD_N)) u_report
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .err_evt(err_evt),
      .sev_eff(sev_eff),
      .report_fatal(report_fatal),
      .report_nonfatal(report_nonfatal)
   );

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sev_write;
      ce && wr_en && hit(wr_req.addr, `UES_SEV_OFS) && wr_req.strb[`UES_SEV_LANE];
   endsequence

   sequence s_sev_read;
      ce && s_arvalid && s_arready && hit(s_araddr, `UES_SEV_OFS);
   endsequence

   sequence s_ctl_write;
      ce && wr_en && hit(wr_req.addr, `UES_CTL_OFS) && wr_req.strb[`UES_CTL_LANE];
   endsequence

   sequence s_err_seen;
      ce && (|err_evt);
   endsequence

   a_completion_timeout_sev_reads_zero: assert property (s_sev_read |=> s_rvalid && !s_rdata[`UES_COMPLETION_TIMEOUT_SEV_BIT]) // RULE1
      else $error("completion timeout severity read as one");

   a_completer_abort_sev_reads_zero: assert property (s_sev_read |=> !s_rdata[`UES_COMPLETER_ABORT_SEV_BIT] && s_rresp == `UES_RESP_OKAY) // RULE2
      else $error("completer abort severity read as one");

   a_fatal_class: assert property (ce && |(err_evt & sev_eff) |=> report_fatal) // RULE3
      else $error("error with selector set not reported fatal");

   a_nonfatal_class: assert property (ce && |(err_evt & ~sev_eff) |=> report_nonfatal) // RULE3
      else $error("error with selector clear not reported non-fatal");

   a_reset_defaults: assert property (@(posedge aclk) $rose(aresetn) |-> sev_ff == `UES_SEV_RST) // RULE4
      else $error("severity selectors wrong after reset");

   a_interr_locked: assert property ((!ie_en and s_sev_write) |=> sev_eff[`UES_INTERR_BIT-`UES_FIELD_LO]
      && $stable(sev_ff[`UES_INTERR_BIT-`UES_PROG_LO])) // RULE5
      else $error("internal error severity changed while locked");

   a_mcblk_locked: assert property ((!mc_off and s_sev_write) |=> !sev_eff[`UES_MCBLK_BIT-`UES_FIELD_LO]
      && $stable(sev_ff[`UES_MCBLK_BIT-`UES_PROG_LO])) // RULE6
      else $error("multicast blocked severity changed while locked");

   a_mcblk_writable: assert property ((mc_off and s_sev_write) ##1 mc_off |-> sev_eff[`UES_MCBLK_BIT-`UES_FIELD_LO]
      == $past(wr_req.data[`UES_MCBLK_BIT])) // RULE6
      else $error("multicast blocked severity not written when unlocked");

   a_sticky_hot_reset: assert property (hot_reset && !wr_en |=> $stable(sev_ff)) // RULE7
      else $error("severity selectors lost on hot reset");

   a_reserved_zero: assert property (s_sev_read ##1 s_rvalid |-> s_rdata[31:24] == 8'h00) // RULE7
      else $error("reserved severity bits read nonzero");

   // the effective view always honours the hardwired and forced bits
   a_completion_timeout_sev_hardwired: assert property (sev_out[`UES_COMPLETION_TIMEOUT_SEV_BIT-`UES_FIELD_LO] == 1'b0) // RULE1
      else $error("completion timeout severity not hardwired low");

   a_completer_abort_sev_hardwired: assert property (sev_out[`UES_COMPLETER_ABORT_SEV_BIT-`UES_FIELD_LO] == 1'b0) // RULE2
      else $error("completer abort severity not hardwired low");

   a_interr_forced: assert property (!ie_en |->
      sev_out[`UES_INTERR_BIT-`UES_FIELD_LO] == `UES_INTERR_FORCED) // RULE5
      else $error("internal error severity not forced while locked");

   a_mcblk_forced: assert property (!mc_off |->
      sev_out[`UES_MCBLK_BIT-`UES_FIELD_LO] == `UES_MCBLK_FORCED) // RULE6
      else $error("multicast blocked severity not forced while locked");

   a_interr_writable: assert property ((ie_en and s_sev_write) ##1 ie_en |-> sev_eff[`UES_INTERR_BIT-`UES_FIELD_LO]
      == $past(wr_req.data[`UES_INTERR_BIT])) // RULE5
      else $error("internal error severity not written when unlocked");

   // writes land in the programmable selectors and the control bits
   a_prog_written: assert property (s_sev_write |=> sev_ff[`UES_ACS_BIT-`UES_PROG_LO:0]
      == $past(wr_req.data[`UES_ACS_BIT:`UES_PROG_LO])) // RULE3
      else $error("programmable severity selectors not written");

   a_ctl_written: assert property (s_ctl_write |=> ctl_ff[`UES_CTL_MCOFF_BIT:`UES_CTL_IEEN_BIT]
      == $past(wr_req.data[`UES_CTL_MCOFF_BIT:`UES_CTL_IEEN_BIT]))
      else $error("control bits not written");

   a_sev_write_resp: assert property (s_sev_write |=> s_bvalid && s_bresp == `UES_RESP_OKAY)
      else $error("severity write not acknowledged okay");

   // sticky state moves only on a write, never on hot reset or while frozen
   a_sev_hold: assert property (!(ce && wr_en) |=> $stable(sev_ff)) // RULE7
      else $error("severity selectors changed without a write");

   a_ctl_sticky: assert property (hot_reset && !wr_en |=> $stable(ctl_ff)) // RULE7
      else $error("control bits lost on hot reset");

   a_ce_freeze: assert property (!ce |=> $stable(sev_ff) && $stable(ctl_ff) && $stable(report_fatal)
      && $stable(report_nonfatal))
      else $error("state moved while clock enable low");

   // lower 14 bits of the word belong to another block
   a_sev_lower_zero: assert property (s_sev_read |=> s_rdata[`UES_FIELD_LO-1:0] == '0)
      else $error("lower severity bits read nonzero");

   // no error, no report; any error gives some report
   a_report_quiet: assert property (ce && !(|err_evt) |=> !report_fatal && !report_nonfatal) // RULE3
      else $error("report without a detected error");

   a_err_classified: assert property (s_err_seen |=> report_fatal || report_nonfatal) // RULE3
      else $error("detected error not reported");
endmodule : ues_top

// ---- tb/ues_top_test.sv ----
`timescale 1ns/1ps
`include "ues_regs.svh"
module ues_top_test;
   import ues_pkg::*;

   // clock, resets and bus signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic hot_reset = 1'b0;
   logic s_awvalid = 1'b0, s_awready, s_wvalid = 1'b0, s_wready, s_bvalid, s_bready = 1'b0;
   logic [`UES_ADDR_W-1:0] s_awaddr = 12'h000, s_araddr = 12'h000;
   logic [`UES_DATA_W-1:0] s_wdata = 32'h0, s_rdata;
   logic [3:0] s_wstrb = 4'h0;
   logic [1:0] s_bresp, s_rresp;
   logic s_arvalid = 1'b0, s_arready, s_rvalid, s_rready = 1'b0;
   logic [`UES_FIELD_N-1:0] err_evt = 10'h000, sev_out;
   logic report_fatal, report_nonfatal;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   ues_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .hot_reset(hot_reset),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr), .s_awprot(3'h0),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_arprot(3'h0),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .err_evt(err_evt), .report_fatal(report_fatal), .report_nonfatal(report_nonfatal), .sev_out(sev_out));

   // 10 MHz clock
   always #50 aclk = ~aclk;

   // whole run needs well under 2000 cycles; cut a hang short
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // fundamental reset, held 8 cycles; called right after an edge
   task automatic full_reset();
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : full_reset

   // write: address and data offered together, each released once taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_awvalid <= 1'b1;
      s_awaddr <= a;
      s_wvalid <= 1'b1;
      s_wdata <= d;
      s_wstrb <= st;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         if (!aw_done && s_awready)
         begin
            aw_done = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (!w_done && s_wready)
         begin
            w_done = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      s_bready <= 1'b1;
      do @(posedge aclk); while (s_bvalid !== 1'b1);
      resp = s_bresp;
      s_bready <= 1'b0;
   endtask : axi_write

   // read: rready held high until rvalid is seen
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      s_arvalid <= 1'b1;
      s_araddr <= a;
      do @(posedge aclk); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      s_rready <= 1'b1;
      do @(posedge aclk); while (s_rvalid !== 1'b1);
      d = s_rdata;
      resp = s_rresp;
      s_rready <= 1'b0;
   endtask : axi_read

   // write one register, expecting an okay response
   task automatic wr_ok(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
      logic [1:0] r;
      axi_write(a, d, st, r);
      check({30'h0, r}, {30'h0, `UES_RESP_OKAY}, "bresp");
   endtask : wr_ok

   // read one register and compare the word
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check({30'h0, r}, {30'h0, `UES_RESP_OKAY}, "rresp");
      check(d, exp, what);
   endtask : rd_chk

   task automatic t_reset_values();
      rd_chk(`UES_SEV_OFS, 32'h0046_0000, "sev after reset");
      rd_chk(`UES_CTL_OFS, 32'h0000_0000, "ctl after reset");
   endtask : t_reset_values

   // all ones on all lanes: hardwired, reserved and locked bits must hold
   task automatic t_locked_writes();
      wr_ok(`UES_SEV_OFS, 32'hFFFF_FFFF, 4'hF);
      rd_chk(`UES_SEV_OFS, 32'h007F_0000, "sev all ones locked");
      wr_ok(`UES_SEV_OFS, 32'h0000_0000, 4'h4);
      rd_chk(`UES_SEV_OFS, 32'h0040_0000, "sev zeros locked");
   endtask : t_locked_writes

   // unlock both selectors, then lock again over differing stored values
   task automatic t_unlock();
      wr_ok(`UES_CTL_OFS, 32'h0000_0003, 4'h1);
      wr_ok(`UES_SEV_OFS, 32'h00AA_0000, 4'h4);
      rd_chk(`UES_SEV_OFS, 32'h00AA_0000, "sev unlocked");
      wr_ok(`UES_CTL_OFS, 32'h0000_0000, 4'h1);
      rd_chk(`UES_SEV_OFS, 32'h006A_0000, "sev relocked");
   endtask : t_unlock

   // pulse each error type and compare its classification
   task automatic t_reports(input logic [31:0] sev);
      for (int k = 0; k < `UES_FIELD_N; k++)
      begin
         err_evt <= 10'h001 << k;
         @(posedge aclk);
         err_evt <= 10'h000;
         @(negedge aclk);
         check({22'h0, sev_out}, {22'h0, sev[23:14]}, "sev_out");
         check({31'h0, report_fatal}, {31'h0, sev[14+k]}, "fatal report");
         check({31'h0, report_nonfatal}, {31'h0, ~sev[14+k]}, "nonfatal report");
         @(posedge aclk);
      end
   endtask : t_reports

   // hot reset keeps selectors, fundamental reset restores their reset value
   task automatic t_resets();
      hot_reset <= 1'b1;
      repeat (2) @(posedge aclk);
      hot_reset <= 1'b0;
      @(posedge aclk);
      rd_chk(`UES_SEV_OFS, 32'h00AA_0000, "sev after hot reset");
      rd_chk(`UES_CTL_OFS, 32'h0000_0003, "ctl after hot reset");
      full_reset();
      rd_chk(`UES_SEV_OFS, 32'h0046_0000, "sev after full reset");
   endtask : t_resets

   // unmapped address answers with an error and changes nothing
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      axi_write(12'h300, 32'hFFFF_FFFF, 4'hF, r);
      check({30'h0, r}, {30'h0, `UES_RESP_SLVERR}, "unmapped bresp");
      axi_read(12'h300, d, r);
      check({30'h0, r}, {30'h0, `UES_RESP_SLVERR}, "unmapped rresp");
      check(d, 32'h0, "unmapped rdata");
      rd_chk(`UES_SEV_OFS, 32'h0046_0000, "sev after unmapped");
   endtask : t_unmapped

   // enable low: no handshake offered, no report, nothing moves
   task automatic t_freeze();
      ce <= 1'b0;
      err_evt <= 10'h3FF;
      @(posedge aclk);
      err_evt <= 10'h000;
      @(negedge aclk);
      check({29'h0, s_awready, s_wready, s_arready}, 32'h0, "ready while frozen");
      check({30'h0, report_fatal, report_nonfatal}, 32'h0, "report while frozen");
      @(posedge aclk);
      ce <= 1'b1;
      rd_chk(`UES_SEV_OFS, 32'h0046_0000, "sev after freeze");
   endtask : t_freeze

   // main sequence
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_values();
      t_reports(32'h0046_0000);
      t_locked_writes();
      t_unlock();
      t_reports(32'h006A_0000);
      wr_ok(`UES_CTL_OFS, 32'h0000_0003, 4'h1);
      rd_chk(`UES_SEV_OFS, 32'h00AA_0000, "stored value back");
      t_reports(32'h00AA_0000);
      t_resets();
      t_unmapped();
      t_freeze();
      stop_test();
   end
endmodule : ues_top_test
